// file: design/ctml_mode_logic.v
// CAN transceiver mode, supervision and wake-up logic
`timescale 1ns/1ns
`default_nettype none
`include "ctml_map.vh"

// Summary of operation
// RULE_01: Two modes, selected only by SPI command
// RULE_02: Four slew-rate codes in normal mode
// RULE_03: Sleep honours remote wake-up enable option
// RULE_04: Transmit high gives recessive, lines released
// RULE_05: Transmit low drives bus dominant
// RULE_06: Receive output follows sensed bus state
// RULE_07: Receive output low while supply off
// RULE_08: Undriven transmit input reads recessive
// RULE_09: Driver off after dominant timeout
// RULE_10: Controller keeps at least 60 KBaud
// RULE_11: Reset or normal-request with ballast: pins low
// RULE_12: Standby with ballast: pins low
// RULE_13: Powered sleep holds pins high
// RULE_14: Interrupt pulse 80 us after third pulse
// RULE_15: Three valid dominant pulses within window
// RULE_16: Stuck flag clears on fault end and read
// RULE_17: Stop-mode wake-ups pulse the interrupt output
// RULE_18: Driver re-enables when transmit returns high
module ctml_mode_logic #(
	parameter integer DOM_TIMEOUT_CYC =
		(`CTML_DOM_TIMEOUT_NS * 1000 + `CTML_CLK_PS - 1) / `CTML_CLK_PS,
	parameter integer WU_PMAX_CYC =
		(`CTML_WU_PMAX_NS * 1000) / `CTML_CLK_PS,
	parameter integer WU_WIN_CYC =
		(`CTML_WU_WIN_NS * 1000) / `CTML_CLK_PS,
	parameter integer IRQ_DLY_CYC =
		(`CTML_IRQ_DLY_NS * 1000) / `CTML_CLK_PS
) (
	input  wire       core_clk,
	input  wire       sys_rst,
	input  wire       spi_mode_wr,
	input  wire       spi_mode_sel,
	input  wire [1:0] spi_slew_sel,
	input  wire       spi_wake_en,
	input  wire       spi_status_rd,
	input  wire [2:0] chip_mode,
	input  wire       ext_ballast,
	input  wire       interface_supply_rail,
	input  wire       other_wake,
	input  wire       tx_pin,
	input  wire       tx_pin_driven,
	input  wire       bus_dominant,
	output reg        rx_pin,
	output reg        tx_level,
	output reg        drv_dominant,
	output reg        drv_enable,
	output reg  [1:0] slew_rate,
	output reg        can_mode,
	output reg        wake_armed,
	output reg        can_wakeup_flag,
	output reg        tx_stuck_flag,
	output reg        irq_n
);

	localparam integer PMIN_CYC =
		(`CTML_WU_PMIN_NS * 1000 + `CTML_CLK_PS - 1) / `CTML_CLK_PS;
	localparam integer IRQ_W_CYC =
		(`CTML_IRQ_W_NS * 1000) / `CTML_CLK_PS;
	localparam [2:0] S_IDLE = 3'h1;
	localparam [2:0] S_WAIT = 3'h2;
	localparam [2:0] S_PULSE = 3'h4;

	// Saturating counter step
	function [19:0] ctml_inc;
		input [19:0] v;
		begin
			ctml_inc = (v == 20'hFFFFF) ? v : v + 20'h00001;
		end
	endfunction

	// Pin synchronisers
	reg [1:0] tx_sync_reg;
	reg [1:0] txd_sync_reg;
	reg [1:0] bus_sync_reg;
	reg [1:0] sup_sync_reg;
	reg [1:0] ow_sync_reg;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_sync_reg  <= 2'h3;
			txd_sync_reg <= 2'h0;
			bus_sync_reg <= 2'h0;
			sup_sync_reg <= 2'h0;
			ow_sync_reg  <= 2'h0;
		end else begin
			tx_sync_reg  <= {tx_sync_reg[0], tx_pin};
			txd_sync_reg <= {txd_sync_reg[0], tx_pin_driven};
			bus_sync_reg <= {bus_sync_reg[0], bus_dominant};
			sup_sync_reg <= {sup_sync_reg[0], interface_supply_rail};
			ow_sync_reg  <= {ow_sync_reg[0], other_wake};
		end
	end

	wire tx_hi   = tx_sync_reg[1] | ~txd_sync_reg[1]; // RULE_08
	wire bus_dom = bus_sync_reg[1];
	wire sup_on  = sup_sync_reg[1];
	wire ow      = ow_sync_reg[1];
	wire in_stop = (chip_mode == `CTML_CHIP_STOP);
	// Supply is off in these chip modes when a ballast is fitted
	wire bal_off = ext_ballast & ((chip_mode == `CTML_CHIP_RESET) |
		(chip_mode == `CTML_CHIP_NREQ) |
		(chip_mode == `CTML_CHIP_STANDBY)); // RULE_11 RULE_12
	wire pow_on = sup_on & ~bal_off & (chip_mode != `CTML_CHIP_SLEEP) &
		~in_stop;

	// Mode, slew and wake option, changed only by SPI write
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			can_mode   <= `CTML_MODE_NORMAL;
			slew_rate  <= `CTML_SLEW_RST;
			wake_armed <= 1'b0;
		end else if (spi_mode_wr) begin // RULE_01
			can_mode  <= spi_mode_sel;
			slew_rate <= spi_slew_sel; // RULE_02
			if (spi_mode_sel == `CTML_MODE_SLEEP)
				wake_armed <= spi_wake_en; // RULE_03
			else
				wake_armed <= 1'b0;
		end
	end

	// Stuck-dominant timeout and driver disable
	reg [19:0] dom_cnt_reg;
	reg        tx_fault_reg;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dom_cnt_reg  <= 20'h00000;
			tx_fault_reg <= 1'b0;
		end else if (tx_hi) begin
			dom_cnt_reg  <= 20'h00000;
			tx_fault_reg <= 1'b0; // RULE_18
		end else begin
			dom_cnt_reg <= ctml_inc(dom_cnt_reg);
			if (dom_cnt_reg >= DOM_TIMEOUT_CYC[19:0] - 20'h00001)
				tx_fault_reg <= 1'b1; // RULE_09
		end
	end

	// Latched stuck flag: set wins, clear needs fault gone and read
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			tx_stuck_flag <= 1'b0;
		else if (tx_fault_reg)
			tx_stuck_flag <= 1'b1; // RULE_16
		else if (spi_status_rd)
			tx_stuck_flag <= 1'b0; // RULE_16
	end

	// Pin and driver outputs per power and interface mode
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_pin       <= 1'b0;
			tx_level     <= 1'b0;
			drv_dominant <= 1'b0;
			drv_enable   <= 1'b0;
		end else if (!pow_on) begin
			rx_pin       <= 1'b0; // RULE_07 RULE_11 RULE_12
			tx_level     <= 1'b0;
			drv_dominant <= 1'b0;
			drv_enable   <= 1'b0;
		end else if (can_mode == `CTML_MODE_SLEEP) begin
			rx_pin       <= 1'b1; // RULE_13
			tx_level     <= 1'b1;
			drv_dominant <= 1'b0;
			drv_enable   <= 1'b0;
		end else begin
			rx_pin       <= ~bus_dom; // RULE_06
			tx_level     <= tx_hi;
			drv_enable   <= ~tx_fault_reg; // RULE_09
			drv_dominant <= ~tx_hi & ~tx_fault_reg; // RULE_04 RULE_05
		end
	end

	// Pattern wake-up detector on the bus receiver
	reg        bus_d_reg;
	reg [19:0] pulse_cnt_reg;
	reg [19:0] gap_cnt_reg;
	reg [19:0] win_cnt_reg;
	reg [1:0]  npulse_reg;
	reg        wake_det;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_d_reg     <= 1'b0;
			pulse_cnt_reg <= 20'h00000;
			gap_cnt_reg   <= 20'h00000;
			win_cnt_reg   <= 20'h00000;
			npulse_reg    <= 2'h0;
			wake_det      <= 1'b0;
		end else begin
			bus_d_reg <= bus_dom;
			wake_det  <= 1'b0;
			if (!wake_armed) begin
				npulse_reg  <= 2'h0;
				win_cnt_reg <= 20'h00000;
			end else if (bus_dom) begin
				pulse_cnt_reg <= ctml_inc(pulse_cnt_reg);
				gap_cnt_reg   <= 20'h00000;
				if (npulse_reg != 2'h0)
					win_cnt_reg <= ctml_inc(win_cnt_reg);
				if (pulse_cnt_reg >= WU_PMAX_CYC[19:0])
					npulse_reg <= 2'h0;
			end else begin
				pulse_cnt_reg <= 20'h00000;
				if (npulse_reg != 2'h0) begin
					gap_cnt_reg <= ctml_inc(gap_cnt_reg);
					win_cnt_reg <= ctml_inc(win_cnt_reg);
				end
				if (gap_cnt_reg >= WU_PMAX_CYC[19:0] ||
					win_cnt_reg >= WU_WIN_CYC[19:0]) begin
					npulse_reg  <= 2'h0;
					win_cnt_reg <= 20'h00000;
				end else if (bus_d_reg &&
					pulse_cnt_reg >= PMIN_CYC[19:0] &&
					pulse_cnt_reg < WU_PMAX_CYC[19:0]) begin // RULE_15
					if (npulse_reg == 2'h2) begin
						wake_det    <= 1'b1;
						npulse_reg  <= 2'h0;
						win_cnt_reg <= 20'h00000;
					end else
						npulse_reg <= npulse_reg + 2'h1;
				end
			end
		end
	end

	// Sticky wake-up flag, cleared by read in normal mode; set wins
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			can_wakeup_flag <= 1'b0;
		else if (wake_det)
			can_wakeup_flag <= 1'b1;
		else if (spi_status_rd && can_mode == `CTML_MODE_NORMAL)
			can_wakeup_flag <= 1'b0;
	end

	// Stop-mode interrupt pulse sequencer
	reg [2:0]  irq_st_reg;
	reg [19:0] irq_cnt_reg;
	always @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_st_reg  <= S_IDLE;
			irq_cnt_reg <= 20'h00000;
			irq_n       <= 1'b1;
		end else begin
			case (irq_st_reg)
				S_IDLE: begin
					irq_n       <= 1'b1;
					irq_cnt_reg <= 20'h00000;
					if (in_stop && (wake_det || ow)) // RULE_17
						irq_st_reg <= S_WAIT;
				end
				S_WAIT: begin
					irq_cnt_reg <= ctml_inc(irq_cnt_reg);
					if (irq_cnt_reg >= IRQ_DLY_CYC[19:0] - 20'h00001) begin
						irq_st_reg  <= S_PULSE; // RULE_14
						irq_cnt_reg <= 20'h00000;
						irq_n       <= 1'b0;
					end
				end
				S_PULSE: begin
					irq_cnt_reg <= ctml_inc(irq_cnt_reg);
					if (irq_cnt_reg >= IRQ_W_CYC[19:0] - 20'h00001) begin
						irq_st_reg <= S_IDLE;
						irq_n      <= 1'b1;
					end
				end
				default: begin
					irq_st_reg <= S_IDLE;
					irq_n      <= 1'b1;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// file: design/ctml_map.vh
// Constants for the CAN transceiver mode and supervision logic
`ifndef CTML_MAP_VH
`define CTML_MAP_VH
// Core clock period in picoseconds (125 MHz)
`define CTML_CLK_PS          8000
// Stuck-dominant transmit timeout, least time, in ns
`define CTML_DOM_TIMEOUT_NS  200000
// Wake-up pulse shortest dominant time, in ns
`define CTML_WU_PMIN_NS      500
// Wake-up pulse longest dominant time and longest gap, in ns
`define CTML_WU_PMAX_NS      500000
// Wake-up pattern window, in ns
`define CTML_WU_WIN_NS       1000000
// Third pulse to interrupt pulse delay, typical, in ns
`define CTML_IRQ_DLY_NS      80000
// Width of the interrupt pulse, in ns
`define CTML_IRQ_W_NS        1000
// Number of dominant pulses in a wake-up pattern
`define CTML_WU_PULSES       3
// Interface mode codes
`define CTML_MODE_NORMAL     1'b0
`define CTML_MODE_SLEEP      1'b1
// Slew rate after reset
`define CTML_SLEW_RST        2'h0
// Chip mode codes
`define CTML_CHIP_RESET      3'h0
`define CTML_CHIP_NREQ       3'h1
`define CTML_CHIP_NORMAL     3'h2
`define CTML_CHIP_STANDBY    3'h3
`define CTML_CHIP_SLEEP      3'h4
`define CTML_CHIP_STOP       3'h5
`endif

// file: sim/ctml_partner.sv
// Bit-serial CAN controller model driving the transmit pin
`timescale 1ns/1ns
`default_nettype none
module ctml_partner (
	input  wire logic        clk,
	input  wire logic        go,
	input  wire logic        en,
	input  wire logic [15:0] frame,
	output logic             tx,
	output logic             oe
);
	logic [15:0] sh = 16'hFFFF;
	logic [6:0]  n = 7'h00;
	// Frame is sent MSB first, four cycles a bit, then idles recessive
	always @(posedge clk) begin
		if (go) begin
			sh <= frame;
			n  <= 7'h40;
		end else if (n != 7'h00) begin
			n <= n - 7'h01;
			if (n[1:0] == 2'h1)
				sh <= {sh[14:0], 1'b1};
		end
	end
	// A released pin has no pull-up here: it shows the inverse level,
	// so the device's own pull-up handling is what keeps it recessive
	assign oe = en;
	assign tx = en ? sh[15] : ~sh[15];
endmodule
`default_nettype wire

// file: sim/ctml_mode_logic_asserts.sv
// Checker of the CAN transceiver mode logic ports
`timescale 1ns/1ns
`default_nettype none
`include "ctml_map.vh"
module ctml_mode_logic_asserts #(
	parameter integer DOM_TIMEOUT_CYC = 25000
) (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       spi_mode_wr,
	input wire logic       spi_mode_sel,
	input wire logic [1:0] spi_slew_sel,
	input wire logic       spi_wake_en,
	input wire logic       spi_status_rd,
	input wire logic [2:0] chip_mode,
	input wire logic       ext_ballast,
	input wire logic       interface_supply_rail,
	input wire logic       tx_pin,
	input wire logic       tx_pin_driven,
	input wire logic       bus_dominant,
	input wire logic       rx_pin,
	input wire logic       tx_level,
	input wire logic       drv_dominant,
	input wire logic [1:0] slew_rate,
	input wire logic       can_mode,
	input wire logic       wake_armed,
	input wire logic       can_wakeup_flag,
	input wire logic       tx_stuck_flag,
	input wire logic       irq_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire pw = interface_supply_rail && chip_mode == `CTML_CHIP_NORMAL;
	logic [15:0] dcnt;
	// Counts how long the driver has held the bus dominant
	always_ff @(posedge core_clk or posedge sys_rst)
		if (sys_rst) dcnt <= 16'h0000;
		else dcnt <= drv_dominant ? dcnt + 16'h0001 : 16'h0000;
	// Properties
	property p_cfg; spi_mode_wr |=> slew_rate == $past(spi_slew_sel)
		&& can_mode == $past(spi_mode_sel); endproperty
	property p_arm; spi_mode_wr |=>
		wake_armed == $past(spi_mode_sel && spi_wake_en); endproperty
	property p_drv; drv_dominant |->
		!$past(tx_pin, 3) && $past(tx_pin_driven, 3); endproperty
	property p_rx; (pw && can_mode == `CTML_MODE_NORMAL
		&& $stable(bus_dominant))[*4] |-> rx_pin == !bus_dominant; endproperty
	property p_off; (!interface_supply_rail)[*4]
		|-> !rx_pin && !tx_level; endproperty
	property p_bal; (ext_ballast && chip_mode != `CTML_CHIP_NORMAL)[*4]
		|-> !rx_pin && !tx_level; endproperty
	property p_slp; (pw && can_mode == `CTML_MODE_SLEEP)[*4]
		|-> rx_pin && tx_level; endproperty
	property p_tmo; dcnt <= DOM_TIMEOUT_CYC + 2; endproperty
	property p_clr; $fell(tx_stuck_flag)
		|-> $past(spi_status_rd) && $past(tx_pin); endproperty
	property p_irq; $fell(irq_n) |-> $past(chip_mode) == `CTML_CHIP_STOP
		##1 (!irq_n)[*8]; endproperty
	a_cfg: assert property (p_cfg) else $error("config load");
	a_arm: assert property (p_arm) else $error("wake option");
	a_drv: assert property (p_drv) else $error("dominant");
	a_rx: assert property (p_rx) else $error("rx level");
	a_off: assert property (p_off) else $error("supply off");
	a_bal: assert property (p_bal) else $error("ballast");
	a_slp: assert property (p_slp) else $error("sleep pins");
	a_tmo: assert property (p_tmo) else $error("timeout");
	a_clr: assert property (p_clr) else $error("flag clear");
	a_irq: assert property (p_irq) else $error("irq pulse");
	c_irq: cover property ($fell(irq_n));
	c_stk: cover property ($rose(tx_stuck_flag));
	c_wu: cover property ($rose(can_wakeup_flag));
endmodule
bind ctml_mode_logic ctml_mode_logic_asserts
	#(.DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC)) i_chk (.*);
`default_nettype wire

// file: sim/ctml_mode_logic_tb.sv
// Self-checking bench for the CAN transceiver mode logic
`timescale 1ns/1ns
`default_nettype none
`include "ctml_map.vh"
module ctml_mode_logic_tb;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, sel = 1'b0, wen = 1'b0;
	logic rd = 1'b0, bal = 1'b0, sup = 1'b1, ow = 1'b0, ext = 1'b0;
	logic go = 1'b0, en = 1'b1;
	logic [1:0] slw = 2'h0;
	logic [2:0] chip = `CTML_CHIP_NORMAL;
	logic [15:0] frm = 16'hFFFF;
	logic [7:0] r = 8'h5D;
	wire rx, txl, dd, de, cm, wa, wf, sf, irq, ptx, poe;
	wire [1:0] sr;
	wire bd = dd | ext;
	int err_total = 0, tests_run = 0, n, w, e;
	// Clock at 8 ns
	initial forever #4 clk = ~clk;
	ctml_partner i_ptn (.clk(clk), .go(go), .en(en), .frame(frm),
		.tx(ptx), .oe(poe));
	ctml_mode_logic #(.DOM_TIMEOUT_CYC(50), .WU_PMAX_CYC(100),
		.WU_WIN_CYC(400), .IRQ_DLY_CYC(20)) i_dut (
		.core_clk(clk), .sys_rst(rst), .spi_mode_wr(wr),
		.spi_mode_sel(sel), .spi_slew_sel(slw), .spi_wake_en(wen),
		.spi_status_rd(rd), .chip_mode(chip), .ext_ballast(bal),
		.interface_supply_rail(sup), .other_wake(ow), .tx_pin(ptx),
		.tx_pin_driven(poe), .bus_dominant(bd), .rx_pin(rx),
		.tx_level(txl), .drv_dominant(dd), .drv_enable(de),
		.slew_rate(sr), .can_mode(cm), .wake_armed(wa),
		.can_wakeup_flag(wf), .tx_stuck_flag(sf), .irq_n(irq));
	// Fibonacci shift register for random values
	function automatic [7:0] lf(input [7:0] s);
		lf = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chk(input logic [7:0] x, input logic [7:0] g);
		tests_run++;
		if (x !== g) begin
			err_total++;
			$display("mismatch at %0t: exp %h got %h", $time, x, g);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic mode(input logic m, input logic [1:0] s, input logic v);
		{sel, slw, wen, wr} = {m, s, v, 1'b1};
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	task automatic rdst;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		cyc(1);
	endtask
	task automatic snd(input logic [15:0] f);
		{frm, go} = {f, 1'b1};
		cyc(1);
		go = 1'b0;
	endtask
	// Three dominant pulses of the given width, gaps of 20 cycles
	task automatic pls(input int k);
		repeat (3) begin
			cyc(20);
			ext = 1'b1;
			cyc(k);
			ext = 1'b0;
		end
	endtask
	task automatic wirq;
		n = 0;
		while (irq !== 1'b0 && n < 200) begin
			cyc(1);
			n++;
		end
		if (n >= 200) begin
			err_total++;
			end_sim;
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Main sequence
	initial begin
		cyc(16);
		rst = 1'b0;
		cyc(1);
		chk(8'h01, {4'h0, sr, cm, irq});
		for (int i = 0; i < 8; i++) begin
			r = lf(r);
			mode(r[0], 2'(i), r[1]);
			chk({4'h0, 2'(i), r[0], r[0] & r[1]}, {4'h0, sr, cm, wa});
		end
		$display("test 1 done");
		for (int k = 0; k < 48; k++) begin
			{chip, bal, sup} = {3'(k / 8), k[2], k[1]};
			if (k < 16 && !k[2] && k[1]) continue;
			mode(k[0], 2'h0, 1'b0);
			cyc(4);
			e = sup && chip < 4 && !(bal && chip != `CTML_CHIP_NORMAL);
			chk({6'h00, e[0], e[0]}, {6'h00, rx, txl});
		end
		$display("test 2 done");
		{chip, bal, sup} = {`CTML_CHIP_NORMAL, 2'b01};
		mode(1'b0, 2'h3, 1'b0);
		snd(16'h00FF);
		cyc(12);
		chk(8'h06, {5'h00, dd, de, rx});
		cyc(40);
		chk(8'h01, {6'h00, dd, rx});
		en = 1'b0;
		cyc(8);
		chk(8'h01, {6'h00, dd, txl});
		en = 1'b1;
		snd(16'hF000);
		cyc(70);
		chk(8'h01, {6'h00, sf, de});
		for (int i = 0; i < 6; i++) begin
			r = lf(r);
			snd({r, 8'hFF});
			cyc(66);
			chk(8'h01, {6'h00, sf, rx});
		end
		snd(16'h0000);
		cyc(57);
		chk(8'h04, {5'h00, sf, de, dd});
		rdst;
		chk(8'h01, {7'h00, sf});
		cyc(10);
		chk(8'h03, {6'h00, de, sf});
		rdst;
		chk(8'h00, {7'h00, sf});
		$display("test 3 done");
		chip = `CTML_CHIP_STOP;
		mode(1'b1, 2'h0, 1'b1);
		pls(70);
		wirq;
		chk(8'h03, {6'h00, n >= 20, n <= 26});
		for (w = 0; irq === 1'b0 && w < 200; w++)
			cyc(1);
		chk(8'h7D, 8'(w));
		chk(8'h01, {7'h00, wf});
		mode(1'b1, 2'h0, 1'b0);
		pls(70);
		cyc(100);
		chk(8'h01, {7'h00, irq});
		mode(1'b1, 2'h0, 1'b1);
		pls(40);
		cyc(100);
		chk(8'h01, {7'h00, irq});
		ow = 1'b1;
		wirq;
		ow = 1'b0;
		chk(8'h00, {7'h00, irq});
		cyc(150);
		$display("test 4 done");
		end_sim;
	end
endmodule
`default_nettype wire
